/* dv/tb.sv */
// Self-checking bench for xbsp_top with the partner memory model
`include "xbsp_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, rst, sel, en, wr, strap, pol, ale, rd_n, wl_n, wh_n, trap, irq;
   logic        rdy, prdy, err, rerr;
   logic [11:0] adr;
   logic [31:0] wd, rd, rdat;
   logic [7:0]  dly;
   logic [3:0]  seen;
   int          lowcnt, n_fail, checks_done;

   xbsp_top u_xbsp_top (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .psel(sel), .penable(en),
      .pwrite(wr), .paddr(adr), .pwdata(wd), .prdata(rd), .pready(prdy), .pslverr(err),
      .external_access_select(strap), .ready_in(rdy), .addr_latch_strobe(ale),
      .read_strobe_n(rd_n), .write_low_strobe_n(wl_n), .write_high_strobe_n(wh_n),
      .illegal_bus_trap(trap), .irq(irq));
   xbsp_partner u_xbsp_partner (.sys_clk(sys_clk), .read_strobe_n(rd_n), .write_low_strobe_n(wl_n),
      .write_high_strobe_n(wh_n), .rdy_pol(pol), .rdy_dly(dly), .ready_in(rdy));

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Pin activity and strobe length of one request
   always @(posedge sys_clk) begin
      seen <= seen | {ale, !rd_n, !wl_n, !wh_n};
      if (!(rd_n & wl_n & wh_n)) lowcnt <= lowcnt + 1;
   end
   // Pins {ale, rd, wl, wh} expected for a request
   function automatic logic [3:0] exp_pins(input logic [15:0] c, input logic [4:0] q, input logic h);
      exp_pins = 4'h0;
      if (!h && c[`XBSP_CFG_BUS_ACT] && (q[4] || q[3]))
         exp_pins = !q[0] ? 4'hC : !c[14] ? 4'hA : !q[1] ? 4'hB : q[2] ? 4'h9 : 4'hA;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // APB transfer held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      sel <= 1'b1;
      en <= 1'b0;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge sys_clk);
      en <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (prdy !== 1'b1);
      rdat = rd;
      rerr = err;
      sel <= 1'b0;
      en <= 1'b0;
   endtask
   task automatic do_reset(input logic s);
      rst <= 1'b1;
      strap <= s;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   // One bus request, then pin and strobe length checks
   task automatic run(input logic [15:0] c, input logic [4:0] q, input logic h);
      int k;
      apb(1'b1, `XBSP_OFS_IRQ_STAT, 32'h3);
      apb(1'b1, `XBSP_OFS_CTRL, {31'h0, h});
      apb(1'b1, `XBSP_OFS_DEF_BUSCFG, {16'h0, c});
      pol <= c[`XBSP_CFG_RDY_POL];
      dly <= 8'($urandom_range(0, 6));
      @(negedge sys_clk);
      seen = 4'h0;
      lowcnt = 0;
      apb(1'b1, `XBSP_OFS_CYCLE, {27'h0, q});
      k = 0;
      do begin
         apb(1'b0, `XBSP_OFS_IRQ_STAT, 32'h0);
         k++;
      end while (rdat[0] !== 1'b1 && k < 120 && exp_pins(c, q, h) != 4'h0);
      chk("pins", {28'h0, exp_pins(c, q, h)}, {28'h0, seen});
      if (exp_pins(c, q, h) != 4'h0)
         chk("done", 32'h1, {31'h0, rdat[0]});
      if (exp_pins(c, q, h) != 4'h0 && !c[`XBSP_CFG_RDY_EN])
         chk("len", 32'd2, lowcnt);
      else if (exp_pins(c, q, h) != 4'h0)
         chk("len_rdy", 32'h1, {31'h0, lowcnt >= dly});
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail++;
      final_report;
   end
   // Main sequence
   initial begin
      {rst, sel, en, wr, strap, pol, adr, wd, dly, seen} = {2'h2, 4'h0, 44'h0, 12'h0};
      {lowcnt, n_fail, checks_done} = {32'h0, 32'h0, 32'h0};
      void'($urandom(98));
      do_reset(1'b1);
      apb(1'b0, `XBSP_OFS_DEF_BUSCFG, 32'h0);
      chk("cfg_sc", `XBSP_RST_BUSCFG_SC, rdat);
      apb(1'b0, `XBSP_OFS_STATUS, 32'h0);
      chk("strap", 32'h1, rdat[3]);
      apb(1'b1, `XBSP_OFS_IRQ_MASK, 32'h3);
      run(16'h0, 5'h10, 1'b0);
      chk("trap", 32'h2, {30'h0, rdat[1:0]});
      chk("irq", 32'h1, irq);
      apb(1'b1, `XBSP_OFS_IRQ_MASK, 32'h0);
      @(negedge sys_clk);
      chk("irq_mask", 32'h0, irq);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("slverr", 32'h2, {30'h0, rerr, rdat[0]});
      run(16'h0, 5'h08, 1'b0);
      do_reset(1'b0);
      apb(1'b0, `XBSP_OFS_DEF_BUSCFG, 32'h0);
      chk("cfg_ext", `XBSP_RST_BUSCFG_EXT, rdat);
      run(16'h4600, 5'h17, 1'b0);
      run(16'h0400, 5'h11, 1'b1);
      for (int i = 0; i < 40; i++)
         run(16'($urandom) & 16'h7600, 5'($urandom), i % 9 == 8);
      final_report;
   end
endmodule // tb

/* dv/xbsp_asserts.sv */
// Checker of the strobe pin timing of xbsp_top
module xbsp_asserts #(
   parameter STB_CYC = 2
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Bus pins
   input wire addr_latch_strobe,
   input wire read_strobe_n,
   input wire write_low_strobe_n,
   input wire write_high_strobe_n,
   input wire illegal_bus_trap
);
   // Any read or write strobe low
   wire stb = !(read_strobe_n & write_low_strobe_n & write_high_strobe_n);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Pin assertions
   a_ale_width: assert property ($fell(addr_latch_strobe) |->
      $past(addr_latch_strobe, STB_CYC) && !$past(addr_latch_strobe, STB_CYC + 1))
      else $error("ale pulse width wrong");
   a_ale_then_strobe: assert property ($fell(addr_latch_strobe) |-> stb)
      else $error("no strobe after ale");
   a_rd_wr_excl: assert property (!(!read_strobe_n &&
      !(write_low_strobe_n & write_high_strobe_n))) else $error("read and write together");
   a_strobe_min: assert property ($rose(stb) |=> stb)
      else $error("strobe shorter than two cycles");
   // The data phase count, ready or the time-out must end every strobe
   a_strobe_bound: assert property ($rose(stb) |-> ##[1:300] !stb)
      else $error("strobe never released");
   // Reset must idle the pins even while it is active
   a_reset_idle: assert property (disable iff (1'b0) rst |->
      !addr_latch_strobe && !stb) else $error("pins not idle in reset");
   a_trap_pulse: assert property (illegal_bus_trap |=> !illegal_bus_trap)
      else $error("trap longer than one cycle");
   a_trap_quiet: assert property (illegal_bus_trap |-> !addr_latch_strobe && !stb)
      else $error("pins moved on trapped access");
   // Main scenarios
   cover property ($rose(addr_latch_strobe));
   cover property ($rose(stb) ##3 stb);
   cover property (illegal_bus_trap);
endmodule // xbsp_asserts

bind xbsp_top xbsp_asserts #(.STB_CYC(STB_CYC)) u_xbsp_asserts (.sys_clk(sys_clk),
   .rst(rst), .addr_latch_strobe(addr_latch_strobe), .read_strobe_n(read_strobe_n),
   .write_low_strobe_n(write_low_strobe_n), .write_high_strobe_n(write_high_strobe_n),
   .illegal_bus_trap(illegal_bus_trap));

/* dv/xbsp_partner.sv */
// External memory model that answers the strobes with a ready signal
module xbsp_partner (
   // Clock and strobes from the device
   input  wire       sys_clk,
   input  wire       read_strobe_n,
   input  wire       write_low_strobe_n,
   input  wire       write_high_strobe_n,
   // Speed and polarity of this part
   input  wire       rdy_pol,
   input  wire [7:0] rdy_dly,
   // Ready back to the device
   output wire       ready_in
);
   timeunit 1ns;
   timeprecision 1ns;
   wire       idle = read_strobe_n & write_low_strobe_n & write_high_strobe_n;
   wire       drv_oe;
   logic [7:0] cnt = 8'h00;
   // Access time counter; a slow part holds ready back
   always @(posedge sys_clk) begin
      cnt <= idle ? 8'h00 : (cnt == 8'hFF ? cnt : cnt + 8'h01);
   end
   // Data drivers open only while the read strobe is low
   assign drv_oe = !read_strobe_n;
   // Ready shows active level once the access time is over
   assign ready_in = (!idle && cnt >= rdy_dly) ? rdy_pol : !rdy_pol;
endmodule // xbsp_partner

/* hw/xbsp_regs.vh */
// Register offsets, field positions, reset values and timing counts of the bus strobe block
`ifndef XBSP_REGS_VH
`define XBSP_REGS_VH

// ==========================================================
// Register byte offsets (APB, one word each)
`define XBSP_OFS_DEF_BUSCFG   12'h000
`define XBSP_OFS_CTRL         12'h004
`define XBSP_OFS_STATUS       12'h008
`define XBSP_OFS_IRQ_STAT     12'h00C
`define XBSP_OFS_IRQ_MASK     12'h010
`define XBSP_OFS_CYCLE        12'h014

// ==========================================================
// Fields of the default bus configuration register
`define XBSP_CFG_RDY_EN       9
`define XBSP_CFG_BUS_ACT      10
`define XBSP_CFG_RDY_ASYNC    12
`define XBSP_CFG_RDY_POL      13
`define XBSP_CFG_WR_SPLIT     14

// Fields of the control register
`define XBSP_CTL_HOLD         0
`define XBSP_CTL_ISOLATE      1

// Fields of the cycle request register
`define XBSP_CYC_WRITE        0
`define XBSP_CYC_BYTE         1
`define XBSP_CYC_HIGH         2
`define XBSP_CYC_XPER         3
`define XBSP_CYC_EXT          4

// Interrupt status bits
`define XBSP_IRQ_DONE         0
`define XBSP_IRQ_TRAP         1

// ==========================================================
// Reset values
`define XBSP_RST_BUSCFG_SC    16'h0000
`define XBSP_RST_BUSCFG_EXT   16'h0400

// ==========================================================
// Timing: strobe phase length in ns, and a cycle time-out in cycles
`define XBSP_STROBE_NS        100
`define XBSP_CLK_NS           50
`define XBSP_RDY_TIMEOUT      255

`endif

/* hw/xbsp_top.v */
// External bus strobe pin logic with its APB register slave
// ==========================================================
// Summary of operation
// - Pulse address latch strobe every external cycle
// - Latch strobe also on separate-address cycles
// - Extension peripherals strobe when bus active
// - No latch strobe for internal accesses
// - No active bus flag: no strobe
// - Latch strobe low in reset, hold, isolate
// - Read strobe low during external reads
// - Read strobe high in reset, hold, isolate
// - One write strobe for byte and word
// - Split mode: low and high byte strobes
// - Write strobe high in reset, hold, isolate
// - Ready ends cycle only when enabled
// - Ready sampled synchronously or asynchronously
// - Bit 13 selects ready polarity
// - Access select sampled at reset release
// - Access select high clears default config
// - External access in single chip traps
`include "xbsp_regs.vh"

module xbsp_top #(
   parameter STB_CYC = (`XBSP_STROBE_NS + `XBSP_CLK_NS - 1) / `XBSP_CLK_NS
) (
   // Clock, reset, enable
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        clk_en,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // External bus pins
   input  wire        external_access_select,
   input  wire        ready_in,
   output reg         addr_latch_strobe,
   output reg         read_strobe_n,
   output reg         write_low_strobe_n,
   output reg         write_high_strobe_n,
   // Trap and interrupt
   output reg         illegal_bus_trap,
   output wire        irq
);

   // ==========================================================
   // States of the bus cycle sequencer
   localparam ST_IDLE  = 2'd0;
   localparam ST_ADDR  = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_WAIT  = 2'd3;
   // Ready time-out reload, sized to the counter
   localparam [7:0] RDY_TMO = `XBSP_RDY_TIMEOUT;

   reg  [15:0] busconf_ff;
   reg  [1:0]  ctrl_ff;
   reg  [1:0]  irq_stat_ff;
   reg  [1:0]  irq_mask_ff;
   reg  [4:0]  cyc_ff;
   reg  [1:0]  state_ff;
   reg  [7:0]  cnt_ff;
   reg         ea_cap_ff;
   reg         ea_done_ff;
   reg         rdy_s1_ff;
   reg         rdy_s2_ff;
   reg         rdy_q_ff;
   reg         timeout_ff;
   reg         [1:0] nxt_state;
   reg         start;

   wire wr_acc = psel & penable & pwrite;
   wire quiet  = ctrl_ff[`XBSP_CTL_HOLD] | ctrl_ff[`XBSP_CTL_ISOLATE];
   wire bus_on = busconf_ff[`XBSP_CFG_BUS_ACT];

   // Zero-wait APB slave; unmapped addresses answer with an error
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `XBSP_OFS_DEF_BUSCFG) | (a == `XBSP_OFS_CTRL)
                | (a == `XBSP_OFS_STATUS) | (a == `XBSP_OFS_IRQ_STAT)
                | (a == `XBSP_OFS_IRQ_MASK) | (a == `XBSP_OFS_CYCLE);
      end
   endfunction

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);

   // ==========================================================
   // Ready input: both paths run, configuration picks one
   // Async path needs two flops; sync path uses one for timing
   wire rdy_raw  = rdy_s2_ff;
   wire rdy_pick = busconf_ff[`XBSP_CFG_RDY_ASYNC] ? rdy_raw : rdy_q_ff;
   wire rdy_act  = busconf_ff[`XBSP_CFG_RDY_POL] ? rdy_pick : ~rdy_pick;
   wire rdy_done = busconf_ff[`XBSP_CFG_RDY_EN] & rdy_act;

   // A request is external when flagged so, or an extension peripheral with bus active
   wire req_ext  = pwdata[`XBSP_CYC_EXT] | (pwdata[`XBSP_CYC_XPER] & bus_on);
   wire req_go   = wr_acc & (paddr == `XBSP_OFS_CYCLE) & (state_ff == ST_IDLE) & ~quiet;
   wire trap_hit = req_go & pwdata[`XBSP_CYC_EXT] & ~bus_on;

   // Sequencer next state
   always @* begin
      nxt_state = state_ff;
      start     = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (req_go & req_ext & ~trap_hit) begin
               nxt_state = ST_ADDR;
               start     = 1'b1;
            end
         end
         ST_ADDR: begin
            if (cnt_ff == 8'd0)
               nxt_state = ST_DATA;
         end
         ST_DATA: begin
            if (cnt_ff == 8'd0)
               nxt_state = busconf_ff[`XBSP_CFG_RDY_EN] ? ST_WAIT : ST_IDLE;
         end
         ST_WAIT: begin
            if (rdy_done | timeout_ff)
               nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ==========================================================
   // Reset capture of access select, after release so no port feeds async reset
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ea_cap_ff  <= 1'b1;
         ea_done_ff <= 1'b0;
      end else if (clk_en && !ea_done_ff) begin
         ea_cap_ff  <= external_access_select;
         ea_done_ff <= 1'b1;
      end
   end

   // Registers, sequencer and counters
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busconf_ff  <= `XBSP_RST_BUSCFG_SC;
         ctrl_ff     <= 2'b00;
         irq_stat_ff <= 2'b00;
         irq_mask_ff <= 2'b00;
         cyc_ff      <= 5'd0;
         state_ff    <= ST_IDLE;
         cnt_ff      <= 8'd0;
         rdy_s1_ff   <= 1'b0;
         rdy_s2_ff   <= 1'b0;
         rdy_q_ff    <= 1'b0;
         timeout_ff  <= 1'b0;
      end else if (clk_en) begin
         rdy_s1_ff <= ready_in;
         rdy_s2_ff <= rdy_s1_ff;
         rdy_q_ff  <= ready_in;
         // Default config follows the strap once, after the release
         if (!ea_done_ff)
            busconf_ff <= external_access_select ? `XBSP_RST_BUSCFG_SC
                                                 : `XBSP_RST_BUSCFG_EXT;
         else if (wr_acc && paddr == `XBSP_OFS_DEF_BUSCFG)
            busconf_ff <= pwdata[15:0];
         if (wr_acc && paddr == `XBSP_OFS_CTRL)
            ctrl_ff <= pwdata[1:0];
         if (wr_acc && paddr == `XBSP_OFS_IRQ_MASK)
            irq_mask_ff <= pwdata[1:0];
         // New events win over a write-one clear in the same cycle
         irq_stat_ff[`XBSP_IRQ_DONE] <= (state_ff != ST_IDLE && nxt_state == ST_IDLE)
            | (irq_stat_ff[`XBSP_IRQ_DONE] & ~(wr_acc && paddr == `XBSP_OFS_IRQ_STAT
                                              && pwdata[`XBSP_IRQ_DONE]));
         irq_stat_ff[`XBSP_IRQ_TRAP] <= trap_hit
            | (irq_stat_ff[`XBSP_IRQ_TRAP] & ~(wr_acc && paddr == `XBSP_OFS_IRQ_STAT
                                              && pwdata[`XBSP_IRQ_TRAP]));
         if (start)
            cyc_ff <= pwdata[4:0];
         // Hold or isolation aborts a running cycle
         state_ff <= quiet ? ST_IDLE : nxt_state;
         if (start || (state_ff == ST_ADDR && cnt_ff == 8'd0))
            cnt_ff <= STB_CYC[7:0] - 8'd1;
         else if (state_ff == ST_DATA && cnt_ff == 8'd0)
            cnt_ff <= RDY_TMO;
         else if (cnt_ff != 8'd0)
            cnt_ff <= cnt_ff - 8'd1;
         timeout_ff <= (state_ff == ST_WAIT) && (cnt_ff == 8'd1);
      end
   end

   // ==========================================================
   // Pin drivers: inactive levels whenever idle, held or isolated
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_latch_strobe   <= 1'b0;
         read_strobe_n       <= 1'b1;
         write_low_strobe_n  <= 1'b1;
         write_high_strobe_n <= 1'b1;
         illegal_bus_trap    <= 1'b0;
      end else if (clk_en) begin
         illegal_bus_trap  <= trap_hit;
         // Internal accesses never reach ST_ADDR, so no strobe for them
         addr_latch_strobe <= ~quiet & (nxt_state == ST_ADDR);
         if (quiet || nxt_state == ST_IDLE || nxt_state == ST_ADDR) begin
            read_strobe_n       <= 1'b1;
            write_low_strobe_n  <= 1'b1;
            write_high_strobe_n <= 1'b1;
         end else begin
            read_strobe_n <= cyc_ff[`XBSP_CYC_WRITE];
            if (!busconf_ff[`XBSP_CFG_WR_SPLIT]) begin
               write_low_strobe_n  <= ~cyc_ff[`XBSP_CYC_WRITE];
               write_high_strobe_n <= 1'b1;
            end else begin
               // Byte lane decode; word writes fire both
               write_low_strobe_n  <= ~(cyc_ff[`XBSP_CYC_WRITE] & ~(cyc_ff[`XBSP_CYC_BYTE]
                                       & cyc_ff[`XBSP_CYC_HIGH]));
               write_high_strobe_n <= ~(cyc_ff[`XBSP_CYC_WRITE] & (~cyc_ff[`XBSP_CYC_BYTE]
                                       | cyc_ff[`XBSP_CYC_HIGH]));
            end
         end
      end
   end

   // Read mux
   always @* begin
      case (paddr)
         `XBSP_OFS_DEF_BUSCFG: prdata = {16'h0000, busconf_ff};
         `XBSP_OFS_CTRL:       prdata = {30'h00000000, ctrl_ff};
         `XBSP_OFS_STATUS:     prdata = {28'h0000000, ea_cap_ff, rdy_act, state_ff};
         `XBSP_OFS_IRQ_STAT:   prdata = {30'h00000000, irq_stat_ff};
         `XBSP_OFS_IRQ_MASK:   prdata = {30'h00000000, irq_mask_ff};
         `XBSP_OFS_CYCLE:      prdata = {27'h0000000, cyc_ff};
         default:              prdata = 32'h00000000;
      endcase
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule // xbsp_top
